// File: core/rts_regs.sv
// register set of a remote-junction thermal sensor, selected by command byte
// assumes a serial engine that decodes byte reads and writes into strobes
`timescale 1ns/10ps
`default_nettype none

module rts_regs #(
  // arbitrary value, not a real maker code
  parameter logic [7:0] MAKER_IDENTIFIER   = 8'h5c,
  // arbitrary value, set per silicon build
  parameter logic [7:0] PART_REVISION_CODE = 8'h00
) (
  input  wire logic                   CLOCK,
  input  wire logic                   SYS_RST,
  input  wire rts_pkg::rts_host_req_t HOST_REQ,
  input  wire rts_pkg::rts_conv_res_t CONV_RES,
  output logic [7:0]                  RD_DATA,
  output logic                        RD_VALID,
  output logic                        CONV_START,
  output logic                        CONV_ABORT,
  output logic                        CONV_BUSY,
  output logic                        POWER_DOWN
);

  // ==========================================================
  // request decode
  logic cfg_write;
  logic [7:0] wdata_clean;

  // writes to any other command byte fall through and change nothing
  assign cfg_write    = HOST_REQ.wr && (HOST_REQ.cmd == rts_pkg::CMD_SETUP_CONTROL);
  // reserved bits are dropped even if the host breaks the write-zero rule
  assign wdata_clean  = HOST_REQ.wdata & ~rts_pkg::RESERVED_MASK;

  // ==========================================================
  // setup control: only the power-down bit is stored
  logic power_down_bit_r;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      power_down_bit_r <= rts_pkg::POWER_DOWN_RESET;
    end else if (cfg_write) begin
      power_down_bit_r <= wdata_clean[rts_pkg::POWER_DOWN_BIT];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      POWER_DOWN <= rts_pkg::POWER_DOWN_RESET;
    end else if (cfg_write) begin
      POWER_DOWN <= wdata_clean[rts_pkg::POWER_DOWN_BIT];
    end
  end

  // ==========================================================
  // conversion sequencer
  logic run_en;
  logic accept;
  logic seq_start;
  logic seq_abort;
  logic seq_busy;

  assign run_en = !wdata_clean[rts_pkg::POWER_DOWN_BIT];

  rts_conv_seq u_seq (
    .clk       (CLOCK),
    .rst       (SYS_RST),
    .run_en    (run_en),
    .cfg_write (cfg_write),
    .conv_done (CONV_RES.done),
    .start_r   (seq_start),
    .abort_r   (seq_abort),
    .busy_r    (seq_busy),
    .accept_r  (accept)
  );

  assign CONV_START = seq_start;
  assign CONV_ABORT = seq_abort;
  assign CONV_BUSY  = seq_busy;

  // ==========================================================
  // result capture, one cycle behind the converter done pulse
  rts_pkg::rts_conv_res_t res_hold_r;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      res_hold_r <= '0;
    end else if (CONV_RES.done) begin
      res_hold_r <= CONV_RES;
    end
  end

  // ==========================================================
  // thermal result register
  logic [7:0] thermal_result_r;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      thermal_result_r <= rts_pkg::THERMAL_RESET;
    end else if (accept) begin
      // converter data is already two's complement, one degree per bit
      if (res_hold_r.fault) begin
        thermal_result_r <= rts_pkg::FULL_SCALE_TEMP;
      end else begin
        thermal_result_r <= res_hold_r.data;
      end
    end
    // no load while halted: shutdown keeps the last reading
  end

  // ==========================================================
  // read path
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = rts_pkg::UNMAPPED_READ;
    case (HOST_REQ.cmd)
      rts_pkg::CMD_THERMAL_RESULT: begin
        rd_mux = thermal_result_r;
      end
      rts_pkg::CMD_SETUP_CONTROL: begin
        rd_mux = 8'h00;
        rd_mux[rts_pkg::POWER_DOWN_BIT] = power_down_bit_r;
      end
      rts_pkg::CMD_MAKER_CODE: begin
        rd_mux = MAKER_IDENTIFIER;
      end
      rts_pkg::CMD_SILICON_REVISION: begin
        rd_mux = PART_REVISION_CODE;
      end
      default: begin
        rd_mux = rts_pkg::UNMAPPED_READ;
      end
    endcase
  end

  // a config read sees the value before a same-cycle write lands
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      RD_DATA  <= 8'h00;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= HOST_REQ.rd;
      if (HOST_REQ.rd) begin
        RD_DATA <= rd_mux;
      end
    end
  end

endmodule

`default_nettype wire

// File: core/rts_pkg.sv
// constants and carrier types of the remote thermal sensor register set
// assumes the serial engine and the converter run on the same 10 MHz clock
package rts_pkg;

  // ==========================================================
  // command byte values
  localparam logic [7:0] CMD_THERMAL_RESULT   = 8'h01;
  localparam logic [7:0] CMD_SETUP_CONTROL    = 8'h03;
  localparam logic [7:0] CMD_MAKER_CODE       = 8'hfe;
  localparam logic [7:0] CMD_SILICON_REVISION = 8'hff;

  // ==========================================================
  // field layout and reset values
  localparam int         POWER_DOWN_BIT       = 6;
  localparam logic [7:0] THERMAL_RESET        = 8'h00;
  localparam logic [7:0] FULL_SCALE_TEMP      = 8'h7f;
  localparam logic       POWER_DOWN_RESET     = 1'b0;
  localparam logic [7:0] UNMAPPED_READ        = 8'h00;
  localparam logic [7:0] RESERVED_MASK        = 8'hbf;

  // ==========================================================
  // carrier types
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } rts_host_req_t;

  typedef struct packed {
    logic       done;
    logic       fault;
    logic [7:0] data;
  } rts_conv_res_t;

endpackage

// File: core/rts_conv_seq.sv
// conversion sequencer: starts, aborts and accepts converter cycles
// assumes the converter answers each start with one done pulse unless aborted
`timescale 1ns/10ps
`default_nettype none

module rts_conv_seq (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run_en,
  input  wire logic cfg_write,
  input  wire logic conv_done,
  output logic      start_r,
  output logic      abort_r,
  output logic      busy_r,
  output logic      accept_r
);

  // ==========================================================
  // state machine
  typedef enum logic [1:0] {
    RTS_LAUNCH,
    RTS_BUSY,
    RTS_HALT
  } rts_seq_state_t;

  rts_seq_state_t state_r;
  rts_seq_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RTS_LAUNCH: begin
        state_nxt = RTS_BUSY;
      end
      RTS_BUSY: begin
        if (conv_done) begin
          state_nxt = RTS_LAUNCH;
        end
      end
      RTS_HALT: begin
        state_nxt = RTS_HALT;
      end
      default: begin
        state_nxt = RTS_HALT;
      end
    endcase
    // a configuration write overrides the current state at once: relaunch, or halt on power-down
    if (cfg_write) begin
      state_nxt = run_en ? RTS_LAUNCH : RTS_HALT;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= RTS_LAUNCH;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // strobes toward the converter and the result register
  always_ff @(posedge clk) begin
    if (rst) begin
      start_r  <= 1'b0;
      abort_r  <= 1'b0;
      busy_r   <= 1'b0;
      accept_r <= 1'b0;
    end else begin
      start_r  <= (state_r == RTS_LAUNCH) && !cfg_write;
      // write wins over a done in the same cycle: partial result dropped
      abort_r  <= cfg_write && (state_r == RTS_BUSY || state_r == RTS_LAUNCH);
      accept_r <= (state_r == RTS_BUSY) && conv_done && !cfg_write;
      busy_r   <= (state_nxt == RTS_BUSY);
    end
  end

endmodule

`default_nettype wire

// File: verification/rts_monitor.sv
// checker of the thermal register set, sees only the top ports
// bound to rts_regs from tb_top
`timescale 1ns/10ps
`default_nettype none
module rts_monitor #(
  parameter logic [7:0] MAKER_IDENTIFIER   = 8'h5c,
  parameter logic [7:0] PART_REVISION_CODE = 8'h00
) (
  input wire logic                   CLOCK,
  input wire logic                   SYS_RST,
  input wire rts_pkg::rts_host_req_t HOST_REQ,
  input wire rts_pkg::rts_conv_res_t CONV_RES,
  input wire logic [7:0]             RD_DATA,
  input wire logic                   RD_VALID,
  input wire logic                   CONV_START,
  input wire logic                   CONV_ABORT,
  input wire logic                   CONV_BUSY,
  input wire logic                   POWER_DOWN
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // ==========================================================
  // register port
  wire logic wcfg = HOST_REQ.wr && HOST_REQ.cmd == rts_pkg::CMD_SETUP_CONTROL;
  wire logic rq   = HOST_REQ.rd && !HOST_REQ.wr;
  a_read_answer: assert property (HOST_REQ.rd |=> RD_VALID)
    else $error("read answer missing");
  a_maker_read: assert property (
    rq && HOST_REQ.cmd == 8'hfe |=> RD_DATA == MAKER_IDENTIFIER)
    else $error("maker code wrong");
  a_rev_read: assert property (
    rq && HOST_REQ.cmd == 8'hff |=> RD_DATA == PART_REVISION_CODE)
    else $error("revision wrong");
  a_cfg_read: assert property (
    rq && HOST_REQ.cmd == 8'h03 |=> RD_DATA == (8'h40 & {8{POWER_DOWN}}))
    else $error("setup read wrong");
  a_pd_write: assert property (
    wcfg |=> POWER_DOWN == $past(HOST_REQ.wdata[6]))
    else $error("shutdown bit not taken");
  a_wr_abort: assert property (
    wcfg && CONV_BUSY |=> CONV_ABORT && !CONV_BUSY)
    else $error("no abort on setup write");
  a_write_restart: assert property (
    wcfg && !HOST_REQ.wdata[6] ##1 !wcfg |=> CONV_START)
    else $error("no restart after write");
  a_halt_quiet: assert property (
    POWER_DOWN && $past(POWER_DOWN) |-> !CONV_START && !CONV_BUSY)
    else $error("converter runs in shutdown");
  c_abort: cover property (wcfg && CONV_BUSY);
  c_fault: cover property (CONV_RES.done && CONV_RES.fault);
  c_temp: cover property (rq && HOST_REQ.cmd == 8'h01);
endmodule
`default_nettype wire

// File: verification/rts_conv_model.sv
// converter model: answers each start after lat edges unless aborted
// data is only valid with done; otherwise it shows the inverse
`timescale 1ns/10ps
`default_nettype none
module rts_conv_model (
  input wire logic              CLOCK,
  input wire logic              SYS_RST,
  input wire logic              CONV_START,
  input wire logic              CONV_ABORT,
  input wire logic [3:0]        lat,
  input wire logic [7:0]        temp,
  input wire logic              fault,
  output var rts_pkg::rts_conv_res_t res
);
  logic [3:0] cnt_r;
  logic       done_w;
  always_ff @(posedge CLOCK) begin
    if (SYS_RST || CONV_ABORT)
      cnt_r <= 4'h0;
    else if (CONV_START)
      cnt_r <= lat;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end
  assign done_w = cnt_r == 4'h1;
  // fields in struct order: done, fault, data
  assign res    = {done_w, done_w & fault, done_w ? temp : ~temp};
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench of the thermal register set
// converter model behind CONV_RES, 100 ns clock
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [7:0] MK = 8'h3c; // arbitrary maker value
  localparam logic [7:0] RV = 8'h07; // arbitrary revision value
  logic CLOCK = 1'b0;
  logic SYS_RST = 1'b1;
  rts_pkg::rts_host_req_t req = '0;
  rts_pkg::rts_conv_res_t res;
  logic [7:0] rdd;
  logic [7:0] temp = 8'h19;
  logic [3:0] lat = 4'h8;
  logic rdv, st, ab, bsy, pd;
  logic fault = 1'b0;
  int errors = 0;
  int cmp_count = 0;
  rts_regs #(.MAKER_IDENTIFIER(MK), .PART_REVISION_CODE(RV)) u_dut (.CLOCK(CLOCK),
    .SYS_RST(SYS_RST), .HOST_REQ(req), .CONV_RES(res), .RD_DATA(rdd), .RD_VALID(rdv),
    .CONV_START(st), .CONV_ABORT(ab), .CONV_BUSY(bsy), .POWER_DOWN(pd));
  rts_conv_model u_cnv (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .CONV_START(st),
    .CONV_ABORT(ab), .lat(lat), .temp(temp), .fault(fault), .res(res));
  initial begin
    forever #50 CLOCK = ~CLOCK;
  end
  // ==========================================================
  // shared tasks
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rd(input logic [7:0] c, input logic [7:0] e);
    @(negedge CLOCK);
    req.rd = 1'b1;
    req.cmd = c;
    @(negedge CLOCK);
    req.rd = 1'b0;
    chk("rd_valid", 8'h01, {7'h00, rdv});
    chk("rd_data", e, rdd);
  endtask
  task wr(input logic [7:0] c, input logic [7:0] d);
    @(negedge CLOCK);
    req.wr = 1'b1;
    req.cmd = c;
    req.wdata = d;
    @(negedge CLOCK);
    req.wr = 1'b0;
  endtask
  task wait_done;
    while (res.done !== 1'b1) @(negedge CLOCK);
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task t_reset;
    // written before the first conversion lands, so only 00h is legal
    wr(8'h01, 8'h55);
    rd(8'h01, 8'h00);
    rd(8'h03, 8'h00);
    $display("reset test over");
  endtask
  task t_ids;
    wr(8'hfe, 8'h55);
    wr(8'hff, 8'h55);
    wr(8'h01, 8'h55);
    rd(8'hfe, MK);
    rd(8'hff, RV);
    $display("id test over");
  endtask
  task t_conv;
    logic [7:0] v[3];
    v = '{8'h19, 8'he7, 8'h80};
    foreach (v[i]) begin
      temp = v[i];
      wait_done;
      repeat (2) @(negedge CLOCK);
      rd(8'h01, v[i]);
    end
    lat = 4'h2;
    fault = 1'b1;
    wait_done;
    repeat (2) @(negedge CLOCK);
    fault = 1'b0;
    rd(8'h01, 8'h7f);
    $display("conversion test over");
  endtask
  task t_abort;
    lat = 4'h8;
    temp = 8'h01;
    wait_done;
    req.wr = 1'b1;
    req.cmd = 8'h03;
    req.wdata = 8'h00;
    @(negedge CLOCK);
    req.wr = 1'b0;
    chk("abort", 8'h01, {7'h00, ab});
    @(negedge CLOCK);
    chk("start", 8'h01, {7'h00, st});
    rd(8'h01, 8'h7f);
    $display("abort test over");
  endtask
  task t_pd;
    wait_done;
    repeat (2) @(negedge CLOCK);
    wr(8'h03, 8'h40);
    chk("power_down", 8'h01, {7'h00, pd});
    rd(8'h03, 8'h40);
    repeat (20) @(negedge CLOCK);
    chk("busy", 8'h00, {7'h00, bsy});
    rd(8'h01, 8'h01);
    wr(8'h03, 8'h00);
    @(negedge CLOCK);
    chk("restart", 8'h01, {7'h00, st});
    $display("shutdown test over");
  endtask
  // reset in mid-run while shut down: defaults must come back
  task t_rerun;
    wr(8'h03, 8'h40);
    @(negedge CLOCK);
    SYS_RST = 1'b1;
    repeat (2) @(negedge CLOCK);
    SYS_RST = 1'b0;
    chk("pd_reset", 8'h00, {7'h00, pd});
    rd(8'h01, 8'h00);
    rd(8'h03, 8'h00);
    $display("reset rerun test over");
  endtask
  initial begin
    repeat (2) @(negedge CLOCK);
    SYS_RST = 1'b0;
    t_reset;
    t_ids;
    t_conv;
    t_abort;
    t_pd;
    t_rerun;
    wrap_up;
  end
  initial begin
    repeat (3000) @(posedge CLOCK);
    errors++;
    wrap_up;
  end
endmodule
bind rts_regs rts_monitor #(.MAKER_IDENTIFIER(MAKER_IDENTIFIER),
  .PART_REVISION_CODE(PART_REVISION_CODE)) u_mon (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
  .HOST_REQ(HOST_REQ), .CONV_RES(CONV_RES), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
  .CONV_START(CONV_START), .CONV_ABORT(CONV_ABORT), .CONV_BUSY(CONV_BUSY),
  .POWER_DOWN(POWER_DOWN));
`default_nettype wire
